// ### logic/cmc_core_memory_cycle_control.sv
// read-rewrite cycle control for the program and data core memories
`timescale 1ns/1ps
`default_nettype none
`include "cmc_defines.svh"
module cmc_core_memory_cycle_control (
    input  wire logic                    core_clk_in,      // 200 MHz clock
    input  wire logic                    rst_n_in,         // async reset
    // program memory requests
    input  wire logic                    pm_req_in,        // fetch request
    input  wire logic [`CMC_ADDR_W-1:0]  pm_addr_in,       // fetch address
    input  wire logic                    stpm_req_in,      // store_to_program_memory
    input  wire logic [`CMC_ADDR_W-1:0]  stpm_addr_in,     // instruction address field
    input  wire logic [`CMC_DM_W-1:0]    stpm_data_in,     // word from data side
    output logic                         pm_busy_out,      // cycle running
    output logic                         pm_done_out,      // cycle complete pulse
    output logic      [`CMC_PM_W-1:0]    pm_data_out,      // output register
    // program memory planes
    output logic      [`CMC_LINES-1:0]   pm_x_sel_out,     // first coordinate
    output logic      [`CMC_LINES-1:0]   pm_y_sel_out,     // second coordinate
    output logic                         pm_read_pol_out,  // read polarity drive
    output logic                         pm_write_pol_out, // reversed polarity drive
    output logic      [`CMC_PM_W-1:0]    pm_inhibit_out,   // inhibit drivers
    input  wire logic [`CMC_PM_W-1:0]    pm_sense_in,      // sense amplifiers
    // data memory requests
    input  wire logic                    dm_req_in,        // operand fetch request
    input  wire logic [`CMC_ADDR_W-1:0]  dm_addr_in,       // operand address
    input  wire logic                    instr_start_in,   // instruction start
    input  wire logic [`CMC_SWITCHES-1:0] switch_closed_in, // discrete switches
    output logic                         dm_busy_out,      // cycle running
    output logic                         dm_done_out,      // cycle complete pulse
    output logic      [`CMC_DM_W-1:0]    dm_data_out,      // output register
    output logic      [`CMC_DM_W-1:0]    operand_out,      // operand register
    // data memory planes
    output logic      [`CMC_LINES-1:0]   dm_x_sel_out,     // first coordinate
    output logic      [`CMC_LINES-1:0]   dm_y_sel_out,     // second coordinate
    output logic                         dm_read_pol_out,  // read polarity drive
    output logic                         dm_write_pol_out, // reversed polarity drive
    output logic      [`CMC_DM_W-1:0]    dm_inhibit_out,   // inhibit drivers
    input  wire logic [`CMC_DM_W-1:0]    dm_sense_in       // sense amplifiers
);
    localparam logic [`CMC_TMR_W-1:0] CYCLE_LAST = `CMC_TMR_W'(`CMC_CYCLE_CYC - 1);
    localparam logic [`CMC_TMR_W-1:0] PM_SLOT    = `CMC_TMR_W'(0);
    localparam logic [`CMC_TMR_W-1:0] DM_SLOT    = `CMC_TMR_W'(`CMC_HALF_CYC);
    localparam logic [`CMC_TMR_W-1:0] READ_LAST  = `CMC_TMR_W'(`CMC_READ_CYC - 1);
    localparam logic [`CMC_TMR_W-1:0] WRITE_LAST = `CMC_TMR_W'(`CMC_WRITE_CYC - 1);

    logic                      rst_meta_reg;
    logic                      rst_sync_reg;
    logic [`CMC_TMR_W-1:0]     slot_tmr_reg;
    cmc_pkg::cmc_state_type    pm_state_reg;
    cmc_pkg::cmc_state_type    dm_state_reg;
    logic [`CMC_TMR_W-1:0]     pm_cnt_reg;
    logic [`CMC_TMR_W-1:0]     dm_cnt_reg;
    logic [`CMC_ADDR_W-1:0]    pm_addr_reg;
    logic [`CMC_ADDR_W-1:0]    dm_addr_reg;
    logic                      pm_store_reg;
    logic                      dm_mask_reg;
    logic                      pm_take;
    logic                      dm_take;
    logic                      dm_in_switch;
    logic [5:0]                dm_switch_idx;

    // reset release through two flops
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // shared cycle timer fixing the start slot of each memory
    always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            slot_tmr_reg <= '0;
        end else if (slot_tmr_reg == CYCLE_LAST) begin
            slot_tmr_reg <= '0;
        end else begin
            slot_tmr_reg <= slot_tmr_reg + `CMC_TMR_W'(1);
        end
    end

    assign pm_take = (pm_state_reg == cmc_pkg::CMC_IDLE) && (pm_req_in || stpm_req_in)
                     && (slot_tmr_reg == PM_SLOT);
    assign dm_take = (dm_state_reg == cmc_pkg::CMC_IDLE) && dm_req_in
                     && (slot_tmr_reg == DM_SLOT);
    assign dm_in_switch  = (dm_addr_in[`CMC_ADDR_W-1:6] == 6'(`CMC_SWITCH_BASE >> 6));
    assign dm_switch_idx = dm_addr_in[5:0];

    // program memory sequence
    always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            pm_state_reg <= cmc_pkg::CMC_IDLE;
            pm_cnt_reg   <= '0;
        end else begin
            case (pm_state_reg)
                cmc_pkg::CMC_IDLE: begin
                    if (pm_take) begin
                        pm_state_reg <= cmc_pkg::CMC_CLEAR;
                    end
                end
                cmc_pkg::CMC_CLEAR: begin
                    pm_cnt_reg   <= '0;
                    pm_state_reg <= cmc_pkg::CMC_READ;
                end
                cmc_pkg::CMC_READ: begin
                    if (pm_cnt_reg == READ_LAST) begin
                        pm_state_reg <= cmc_pkg::CMC_GAP;
                    end
                    pm_cnt_reg <= pm_cnt_reg + `CMC_TMR_W'(1);
                end
                cmc_pkg::CMC_GAP: begin
                    pm_state_reg <= cmc_pkg::CMC_LATCH;
                end
                cmc_pkg::CMC_LATCH: begin
                    pm_cnt_reg   <= '0;
                    pm_state_reg <= cmc_pkg::CMC_WRITE;
                end
                cmc_pkg::CMC_WRITE: begin
                    if (pm_cnt_reg == WRITE_LAST) begin
                        pm_state_reg <= cmc_pkg::CMC_FINISH;
                    end
                    pm_cnt_reg <= pm_cnt_reg + `CMC_TMR_W'(1);
                end
                default: begin
                    pm_state_reg <= cmc_pkg::CMC_IDLE;
                end
            endcase
        end
    end

    // program memory address register and store flag
    always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            pm_addr_reg  <= '0;
            pm_store_reg <= 1'b0;
        end else if (pm_take) begin
            pm_addr_reg  <= stpm_req_in ? stpm_addr_in : pm_addr_in;
            pm_store_reg <= stpm_req_in;
        end
    end

    // data memory sequence
    always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            dm_state_reg <= cmc_pkg::CMC_IDLE;
            dm_cnt_reg   <= '0;
        end else begin
            case (dm_state_reg)
                cmc_pkg::CMC_IDLE: begin
                    if (dm_take) begin
                        dm_state_reg <= cmc_pkg::CMC_CLEAR;
                    end
                end
                cmc_pkg::CMC_CLEAR: begin
                    dm_cnt_reg   <= '0;
                    dm_state_reg <= cmc_pkg::CMC_READ;
                end
                cmc_pkg::CMC_READ: begin
                    if (dm_cnt_reg == READ_LAST) begin
                        dm_state_reg <= cmc_pkg::CMC_GAP;
                    end
                    dm_cnt_reg <= dm_cnt_reg + `CMC_TMR_W'(1);
                end
                cmc_pkg::CMC_GAP: begin
                    dm_state_reg <= cmc_pkg::CMC_LATCH;
                end
                cmc_pkg::CMC_LATCH: begin
                    dm_cnt_reg   <= '0;
                    dm_state_reg <= cmc_pkg::CMC_WRITE;
                end
                cmc_pkg::CMC_WRITE: begin
                    if (dm_cnt_reg == WRITE_LAST) begin
                        dm_state_reg <= cmc_pkg::CMC_FINISH;
                    end
                    dm_cnt_reg <= dm_cnt_reg + `CMC_TMR_W'(1);
                end
                default: begin
                    dm_state_reg <= cmc_pkg::CMC_IDLE;
                end
            endcase
        end
    end

    // data memory address register and switch mask, caught at the start
    always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            dm_addr_reg <= '0;
            dm_mask_reg <= 1'b0;
        end else if (dm_take) begin
            dm_addr_reg <= dm_addr_in;
            dm_mask_reg <= dm_in_switch && !switch_closed_in[dm_switch_idx];
        end
    end

    // drive polarities, aligned with the registered select lines
    always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            pm_read_pol_out  <= 1'b0;
            pm_write_pol_out <= 1'b0;
            dm_read_pol_out  <= 1'b0;
            dm_write_pol_out <= 1'b0;
        end else begin
            pm_read_pol_out  <= (pm_state_reg == cmc_pkg::CMC_READ);
            pm_write_pol_out <= (pm_state_reg == cmc_pkg::CMC_WRITE);
            dm_read_pol_out  <= (dm_state_reg == cmc_pkg::CMC_READ);
            dm_write_pol_out <= (dm_state_reg == cmc_pkg::CMC_WRITE);
        end
    end

    // handshake toward the processor
    always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            pm_busy_out <= 1'b0;
            pm_done_out <= 1'b0;
            dm_busy_out <= 1'b0;
            dm_done_out <= 1'b0;
        end else begin
            pm_busy_out <= pm_take || (pm_busy_out && pm_state_reg != cmc_pkg::CMC_FINISH);
            pm_done_out <= (pm_state_reg == cmc_pkg::CMC_FINISH);
            dm_busy_out <= dm_take || (dm_busy_out && dm_state_reg != cmc_pkg::CMC_FINISH);
            dm_done_out <= (dm_state_reg == cmc_pkg::CMC_FINISH);
        end
    end

    // operand register: cleared per instruction, skipped when masked
    always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            operand_out <= '0;
        end else if (instr_start_in) begin
            operand_out <= '0;
        end else if (dm_state_reg == cmc_pkg::CMC_FINISH && !dm_mask_reg) begin
            operand_out <= dm_data_out;
        end
    end

    cmc_coord_select u_pm_x (
        .clk_in   (core_clk_in),
        .rst_n_in (rst_sync_reg),
        .addr_in  (pm_addr_reg[5:0]),
        .en_in    (pm_state_reg == cmc_pkg::CMC_READ || pm_state_reg == cmc_pkg::CMC_WRITE),
        .sel_out  (pm_x_sel_out)
    );
    cmc_coord_select u_pm_y (
        .clk_in   (core_clk_in),
        .rst_n_in (rst_sync_reg),
        .addr_in  (pm_addr_reg[11:6]),
        .en_in    (pm_state_reg == cmc_pkg::CMC_READ || pm_state_reg == cmc_pkg::CMC_WRITE),
        .sel_out  (pm_y_sel_out)
    );
    cmc_coord_select u_dm_x (
        .clk_in   (core_clk_in),
        .rst_n_in (rst_sync_reg),
        .addr_in  (dm_addr_reg[5:0]),
        .en_in    (dm_state_reg == cmc_pkg::CMC_READ || dm_state_reg == cmc_pkg::CMC_WRITE),
        .sel_out  (dm_x_sel_out)
    );
    cmc_coord_select u_dm_y (
        .clk_in   (core_clk_in),
        .rst_n_in (rst_sync_reg),
        .addr_in  (dm_addr_reg[11:6]),
        .en_in    (dm_state_reg == cmc_pkg::CMC_READ || dm_state_reg == cmc_pkg::CMC_WRITE),
        .sel_out  (dm_y_sel_out)
    );

    // program word rewritten, or replaced by the stored data word
    cmc_bit_path #(.WIDTH(`CMC_PM_W)) u_pm_bits (
        .clk_in      (core_clk_in),
        .rst_n_in    (rst_sync_reg),
        .clear_in    (pm_state_reg == cmc_pkg::CMC_CLEAR),
        .sense_en_in (pm_read_pol_out),
        .sense_in    (pm_sense_in),
        .latch_in    (pm_state_reg == cmc_pkg::CMC_LATCH),
        .alt_in      (pm_store_reg),
        .alt_data_in (stpm_data_in[`CMC_PM_W-1:0]),
        .inh_en_in   (pm_state_reg == cmc_pkg::CMC_WRITE),
        .out_out     (pm_data_out),
        .inhibit_out (pm_inhibit_out)
    );
    // data word always rewritten as sensed; no path from program side
    cmc_bit_path #(.WIDTH(`CMC_DM_W)) u_dm_bits (
        .clk_in      (core_clk_in),
        .rst_n_in    (rst_sync_reg),
        .clear_in    (dm_state_reg == cmc_pkg::CMC_CLEAR),
        .sense_en_in (dm_read_pol_out),
        .sense_in    (dm_sense_in),
        .latch_in    (dm_state_reg == cmc_pkg::CMC_LATCH),
        .alt_in      (1'b0),
        .alt_data_in ('0),
        .inh_en_in   (dm_state_reg == cmc_pkg::CMC_WRITE),
        .out_out     (dm_data_out),
        .inhibit_out (dm_inhibit_out)
    );

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_sync_reg);

    // start slots
    pm_slot_start_a: assert property ($rose(pm_busy_out) |->
        $past(slot_tmr_reg) == PM_SLOT)
        else $error("program memory started off its slot");
    dm_half_offset_a: assert property ($rose(dm_busy_out) |->
        $past(slot_tmr_reg) == DM_SLOT)
        else $error("data memory not offset by half a cycle");

    // one cycle at a time
    no_overlap_a: assert property (pm_take |-> !pm_busy_out)
        else $error("program memory retaken before rewrite ended");
    dm_no_overlap_a: assert property (dm_take |-> !dm_busy_out)
        else $error("data memory retaken before rewrite ended");
    pm_busy_done_a: assert property ($fell(pm_busy_out) |-> pm_done_out)
        else $error("busy dropped without done");
    dm_busy_done_a: assert property ($fell(dm_busy_out) |-> dm_done_out)
        else $error("busy dropped without done");
    pm_done_pulse_a: assert property (pm_done_out |=> !pm_done_out)
        else $error("done longer than one cycle");
    dm_done_pulse_a: assert property (dm_done_out |=> !dm_done_out)
        else $error("done longer than one cycle");
    done_after_write_a: assert property ($rose(dm_done_out) |->
        $past(dm_write_pol_out, 2) && !dm_write_pol_out)
        else $error("done raised before rewrite finished");

    // rewrite on the read core
    pol_exclusive_a: assert property (!(pm_read_pol_out && pm_write_pol_out)
        && (pm_read_pol_out || pm_write_pol_out) == (|pm_x_sel_out))
        else $error("polarity and selection disagree");
    same_addr_a: assert property ($rose(dm_write_pol_out) |->
        dm_x_sel_out == $past(dm_x_sel_out, 4) && dm_y_sel_out == $past(dm_y_sel_out, 4))
        else $error("rewrite selected another address");
    clear_before_read_a: assert property ((dm_state_reg == cmc_pkg::CMC_CLEAR) |=>
        dm_data_out == '0)
        else $error("output register not cleared");

    // operand register
    operand_clear_a: assert property (instr_start_in |=> operand_out == '0)
        else $error("operand not cleared at instruction start");
    masked_zero_a: assert property ((dm_state_reg == cmc_pkg::CMC_FINISH && dm_mask_reg
        && !instr_start_in) |=> operand_out == $past(operand_out))
        else $error("masked operand reached the operand register");

    // store target
    store_addr_a: assert property ((pm_take && stpm_req_in) |=>
        pm_addr_reg == $past(stpm_addr_in) && pm_store_reg)
        else $error("store address not from the instruction field");
endmodule // cmc_core_memory_cycle_control
`default_nettype wire

// ### include/cmc_defines.svh
// constants for the core memory cycle control block
// What this block does
// - cycle starts on parallel twelve-bit address load
// - four three-bit fields, each decoded one-of-eight
// - low two fields give 64 first-coordinate lines
// - high two fields give 64 second-coordinate lines
// - exactly one line per coordinate is driven
// - sensed ones set output flip-flops, zeros don't
// - data word 22 bits, program word 20
// - each memory holds 4096 words
// - rewrite register restores data, reversed polarity
// - held ones rewritten, held zeros inhibited
// - no new cycle before rewrite ends
// - data memory runs half a cycle later
// - program memory written only by store instruction
// - sixty-four switches, each tied to one address
// - open switch suppresses operand load, stays zero
// - masking never alters the stored word
// - store address comes from instruction address field
`ifndef CMC_DEFINES_SVH
`define CMC_DEFINES_SVH
`define CMC_ADDR_W      12
`define CMC_FIELD_W     3
`define CMC_LINES       64
`define CMC_WORDS       4096
`define CMC_DM_W        22
`define CMC_PM_W        20
`define CMC_SWITCHES    64
`define CMC_SWITCH_BASE 12'h100
`define CMC_CLK_MHZ     200
`define CMC_READ_NS     1000
`define CMC_WRITE_NS    1000
`define CMC_READ_CYC    ((`CMC_READ_NS * `CMC_CLK_MHZ + 999) / 1000)
`define CMC_WRITE_CYC   ((`CMC_WRITE_NS * `CMC_CLK_MHZ + 999) / 1000)
`define CMC_CYCLE_CYC   (`CMC_READ_CYC + `CMC_WRITE_CYC + 8)
`define CMC_HALF_CYC    (`CMC_CYCLE_CYC / 2)
`define CMC_TMR_W       9
`endif

// ### include/cmc_pkg.sv
// types for the core memory cycle control block
`default_nettype none
package cmc_pkg;
    typedef enum logic [2:0] {
        CMC_IDLE,
        CMC_CLEAR,
        CMC_READ,
        CMC_GAP,
        CMC_LATCH,
        CMC_WRITE,
        CMC_FINISH
    } cmc_state_type;
endpackage
`default_nettype wire

// ### logic/cmc_coord_select.sv
// registered one-hot select lines for one coordinate of the core array
`timescale 1ns/1ps
`default_nettype none
`include "cmc_defines.svh"
module cmc_coord_select (
    input  wire logic                    clk_in,   // core clock
    input  wire logic                    rst_n_in, // synchronised reset
    input  wire logic [2*`CMC_FIELD_W-1:0] addr_in, // two address fields
    input  wire logic                    en_in,    // drive enable
    output logic      [`CMC_LINES-1:0]   sel_out   // select lines
);
    logic [7:0] lo_dec;
    logic [7:0] hi_dec;

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_dec
            assign lo_dec[i] = (addr_in[2:0] == 3'(i));
            assign hi_dec[i] = (addr_in[5:3] == 3'(i));
        end
        for (i = 0; i < `CMC_LINES; i++) begin : g_line
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    sel_out[i] <= 1'b0;
                end else begin
                    sel_out[i] <= en_in & hi_dec[i / 8] & lo_dec[i % 8];
                end
            end
        end
    endgenerate

    one_line_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $past(en_in) |-> $onehot(sel_out))
        else $error("select lines not one-hot while driven");
endmodule // cmc_coord_select
`default_nettype wire

// ### logic/cmc_bit_path.sv
// output, rewrite and inhibit registers for the planes of one memory
`timescale 1ns/1ps
`default_nettype none
module cmc_bit_path #(
    parameter int WIDTH = 22
) (
    input  wire logic             clk_in,      // core clock
    input  wire logic             rst_n_in,    // synchronised reset
    input  wire logic             clear_in,    // clear output register
    input  wire logic             sense_en_in, // sense window open
    input  wire logic [WIDTH-1:0] sense_in,    // sense amplifier outputs
    input  wire logic             latch_in,    // load rewrite register
    input  wire logic             alt_in,      // load alternate word
    input  wire logic [WIDTH-1:0] alt_data_in, // alternate word
    input  wire logic             inh_en_in,   // rewrite window open
    output logic      [WIDTH-1:0] out_out,     // output register
    output logic      [WIDTH-1:0] inhibit_out  // inhibit drivers
);
    logic [WIDTH-1:0] rewrite_reg;

    genvar b;
    generate
        for (b = 0; b < WIDTH; b++) begin : g_bit
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    out_out[b] <= 1'b0;
                end else if (clear_in) begin
                    out_out[b] <= 1'b0;
                end else if (sense_en_in && sense_in[b]) begin
                    out_out[b] <= 1'b1;
                end
            end
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    rewrite_reg[b] <= 1'b0;
                end else if (latch_in) begin
                    rewrite_reg[b] <= alt_in ? alt_data_in[b] : out_out[b];
                end
            end
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    inhibit_out[b] <= 1'b0;
                end else begin
                    inhibit_out[b] <= inh_en_in & ~rewrite_reg[b];
                end
            end
        end
    endgenerate

    zero_inhibit_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $past(inh_en_in) |-> (inhibit_out == ~$past(rewrite_reg)))
        else $error("inhibit does not follow the rewrite zeros");
    sense_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (sense_en_in && !clear_in) |=> ((out_out & $past(out_out)) == $past(out_out)))
        else $error("output bit lost during sensing");
endmodule // cmc_bit_path
`default_nettype wire

// ### tb/cmc_core_planes.sv
// behavioural core plane array with destructive read and inhibited rewrite
`timescale 1ns/1ps
`default_nettype none
module cmc_core_planes #(
    parameter int WIDTH = 22
) (
    input  wire logic             clk_in,     // core clock
    input  wire logic [63:0]      x_sel_in,   // first coordinate
    input  wire logic [63:0]      y_sel_in,   // second coordinate
    input  wire logic             rd_pol_in,  // read drive
    input  wire logic             wr_pol_in,  // reversed drive
    input  wire logic [WIDTH-1:0] inhibit_in, // inhibit drivers
    output logic      [WIDTH-1:0] sense_out   // sense amplifiers
);
    logic [WIDTH-1:0] mem_reg [4096];
    logic [WIDTH-1:0] held_reg = '0;
    logic             rd_reg   = 1'b0;
    logic [11:0]      addr;
    initial for (int i = 0; i < 4096; i++) mem_reg[i] = WIDTH'({i[5:0] ^ 6'h2a, i[11:0], 4'h9});
    always_comb begin
        addr = '0;
        for (int i = 0; i < 64; i++) begin
            if (x_sel_in[i]) addr[5:0] = 6'(i);
            if (y_sel_in[i]) addr[11:6] = 6'(i);
        end
    end
    // first read edge empties the cores, the word is then only in held_reg
    always @(posedge clk_in) begin
        rd_reg <= rd_pol_in;
        if (rd_pol_in && !rd_reg) begin
            held_reg      <= mem_reg[addr];
            mem_reg[addr] <= '0;
        end
        if (wr_pol_in) mem_reg[addr] <= mem_reg[addr] | ~inhibit_in;
    end
    // undriven sense lines show the inverse of the last word
    assign sense_out = !rd_pol_in ? ~held_reg : (rd_reg ? held_reg : mem_reg[addr]);
endmodule // cmc_core_planes
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the core memory cycle control
`timescale 1ns/1ps
`default_nettype none
`include "cmc_defines.svh"
module tb_top;
    logic        core_clk_in = 0, rst_n_in = 0, instr_start_in = 0;
    logic        pm_req_in = 0, stpm_req_in = 0, dm_req_in = 0;
    logic [11:0] pm_addr_in = '0, stpm_addr_in = '0, dm_addr_in = '0;
    logic [21:0] stpm_data_in = '0;
    logic [63:0] switch_closed_in = '1;
    logic        pm_busy_out, pm_done_out, pm_read_pol_out, pm_write_pol_out;
    logic        dm_busy_out, dm_done_out, dm_read_pol_out, dm_write_pol_out;
    logic [19:0] pm_data_out, pm_inhibit_out, pm_sense_in;
    logic [21:0] dm_data_out, operand_out, dm_inhibit_out, dm_sense_in;
    logic [63:0] pm_x_sel_out, pm_y_sel_out, dm_x_sel_out, dm_y_sel_out;
    int          n_fail = 0, n_compared = 0;
    always #2.5 core_clk_in = ~core_clk_in;
    cmc_core_memory_cycle_control cmc_core_memory_cycle_control_inst (.*);
    cmc_core_planes #(.WIDTH(20)) cmc_core_planes_pm_inst (.clk_in(core_clk_in),
        .x_sel_in(pm_x_sel_out), .y_sel_in(pm_y_sel_out), .rd_pol_in(pm_read_pol_out),
        .wr_pol_in(pm_write_pol_out), .inhibit_in(pm_inhibit_out), .sense_out(pm_sense_in));
    cmc_core_planes #(.WIDTH(22)) cmc_core_planes_dm_inst (.clk_in(core_clk_in),
        .x_sel_in(dm_x_sel_out), .y_sel_in(dm_y_sel_out), .rd_pol_in(dm_read_pol_out),
        .wr_pol_in(dm_write_pol_out), .inhibit_in(dm_inhibit_out), .sense_out(dm_sense_in));
    function automatic logic [21:0] pat(input logic [11:0] a);
        return {a[5:0] ^ 6'h2a, a, 4'h9};
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        if (n_fail == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // one request held until its done pulse, selects looked at on the first read drive
    task automatic mem_cycle(input bit dm, input bit st, input logic [11:0] a);
        bit seen;
        seen = 0;
        @(posedge core_clk_in);
        {dm_addr_in, pm_addr_in, stpm_addr_in} <= {a, st ? ~a : a, a};
        {dm_req_in, stpm_req_in, pm_req_in} <= {dm, !dm && st, !dm && !st};
        for (int i = 0; i <= 1000; i++) begin
            @(posedge core_clk_in);
            #1;
            if (i == 1000) begin
                n_fail++;
                test_done();
            end
            if (!seen && (dm ? dm_read_pol_out : pm_read_pol_out) === 1'b1) begin
                seen = 1;
                check(dm ? dm_x_sel_out : pm_x_sel_out, 64'h1 << a[5:0]);
                check(dm ? dm_y_sel_out : pm_y_sel_out, 64'h1 << a[11:6]);
                check(dm ? dm_busy_out : pm_busy_out, 64'h1);
            end
            if ((dm ? dm_done_out : pm_done_out) === 1'b1) begin
                check(dm ? dm_busy_out : pm_busy_out, 64'h0);
                break;
            end
        end
        @(posedge core_clk_in);
        {dm_req_in, stpm_req_in, pm_req_in} <= 3'h0;
        #1;
    endtask
    task automatic t_fetch;
        mem_cycle(0, 0, 12'h2c7);
        check(pm_data_out, pat(12'h2c7) & 22'hfffff);
        mem_cycle(0, 0, 12'h2c7);
        check(pm_data_out, pat(12'h2c7) & 22'hfffff);
        mem_cycle(0, 0, 12'hfff);
        check(pm_data_out, pat(12'hfff) & 22'hfffff);
    endtask
    task automatic t_store;
        @(posedge core_clk_in);
        stpm_data_in <= 22'h2a5c3c;
        mem_cycle(0, 1, 12'hfc1);
        check(pm_data_out, pat(12'hfc1) & 22'hfffff);
        mem_cycle(0, 0, 12'hfc1);
        check(pm_data_out, 22'h0a5c3c);
    endtask
    task automatic dm_op(input logic [11:0] a, input logic [21:0] exp);
        @(posedge core_clk_in);
        instr_start_in <= 1;
        @(posedge core_clk_in);
        instr_start_in <= 0;
        #1;
        check(operand_out, 22'h0);
        mem_cycle(1, 0, a);
        check(operand_out, exp);
        check(dm_data_out, pat(a));
    endtask
    task automatic t_mask;
        @(posedge core_clk_in);
        switch_closed_in <= ~64'h1;
        dm_op(12'h100, 22'h0);
        dm_op(12'h101, pat(12'h101));
        @(posedge core_clk_in);
        switch_closed_in <= '0;
        dm_op(12'h13f, 22'h0);
        dm_op(12'h140, pat(12'h140));
        @(posedge core_clk_in);
        switch_closed_in <= '1;
        dm_op(12'h13f, pat(12'h13f));
    endtask
    task automatic t_offset;
        int tp, td;
        tp = -1;
        td = -1;
        @(posedge core_clk_in);
        {pm_req_in, dm_req_in, pm_addr_in, dm_addr_in} <= {2'h3, 12'h055, 12'h0aa};
        for (int i = 0; i < 1200 && (tp < 0 || td < 0); i++) begin
            @(posedge core_clk_in);
            if (tp >= 0) pm_req_in <= 0;
            if (td >= 0) dm_req_in <= 0;
            #1;
            if (pm_done_out === 1'b1) tp = i;
            if (dm_done_out === 1'b1) td = i;
        end
        @(posedge core_clk_in);
        {pm_req_in, dm_req_in} <= 2'h0;
        if (tp < 0 || td < 0) n_fail++;
        if (tp < 0 || td < 0) test_done();
        check(64'((td - tp + 2 * `CMC_CYCLE_CYC) % `CMC_CYCLE_CYC), 64'(`CMC_HALF_CYC));
    endtask
    initial begin
        repeat (4) @(posedge core_clk_in);
        rst_n_in <= 1;
        repeat (4) @(posedge core_clk_in);
        t_fetch();
        t_store();
        t_mask();
        t_offset();
        test_done();
    end
endmodule // tb_top
`default_nettype wire
